//--- core/crs_core.sv
// Purpose: Programmer-visible register set of a 16-bit CPU core.
// Assumes: Core-side strobes are one-cycle pulses in the pclk domain.
// Notes: Core-side updates win over an APB write in the same cycle.
// Function
// - four 16-bit general data registers
// - first two registers split into byte halves
// - third with first, fourth with second: 32-bit
// - two 16-bit address registers, also for data
// - address registers pair, second is upper half
// - 16-bit frame base and static base registers
// - 20-bit vector table base register
// - 20-bit pointer to next instruction
// - user and interrupt stack pointers, 16 bits
// - select flag 0 picks interrupt stack
// - acknowledge or low trap clears stack select
// - flag word is 11 bits of state
// - carry flag captures carry, borrow, shift-out
// - zero flag set on zero result
// - sign flag set on negative result
// - bank select flag picks register bank
// - overflow flag set on overflow
// - interrupt enable flag gates maskable interrupts
// - acknowledge clears interrupt enable flag
// - priority level is 3 bits, 0 to 7
// - accept only priority above current level
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module crs_core (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [crs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core-side updates
  input wire crs_pkg::crs_alu_t alu_upd,
  input wire logic irq_ack,
  input wire logic trap_exec,
  input wire logic [5:0] trap_num,
  input wire logic fetch_load,
  input wire logic [19:0] fetch_value,
  input wire logic sp_load,
  input wire logic [15:0] sp_value,
  input wire crs_pkg::crs_irq_t irq_req,
  // Views for the core
  output crs_pkg::crs_flag_t cpu_flag_word,
  output logic [15:0] active_stack_pointer,
  output logic [31:0] data_pair_low,
  output logic [31:0] data_pair_high,
  output logic [31:0] addr_reg_pair,
  output logic [15:0] frame_base_pointer,
  output logic [15:0] static_base_pointer,
  output logic [19:0] vector_table_base,
  output logic [19:0] next_fetch_pointer,
  output logic irq_eligible
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] bank_reg [crs_pkg::BANKS][crs_pkg::BANKED];
  logic [15:0] user_stack_pointer;
  logic [15:0] interrupt_stack_pointer;
  logic [15:0] static_base;
  logic [19:0] vect_base;
  logic [19:0] fetch_ptr;
  crs_pkg::crs_flag_t flags;
  logic [5:0] widx;
  logic mapped;
  logic wr_en;
  logic [31:0] wmask;
  logic cur_bank;
  logic trap_low;
  crs_pkg::crs_flag_t next_flags;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] val,
                                        input logic [15:0] m);
    merge = (old & ~m) | (val & m);
  endfunction

  function automatic logic is_mapped(input logic [crs_pkg::ADDR_W-1:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a[7:2] <= crs_pkg::IDX_LAST);
  endfunction

  assign widx = paddr[7:2];
  assign mapped = is_mapped(paddr);
  assign wr_en = psel & penable & pwrite & mapped;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign cur_bank = flags.b;
  assign trap_low = trap_exec & (trap_num <= crs_pkg::TRAP_CLR_MAX);

  // ----------------------------------------------------------------
  // Banked data, address and frame base registers
  // ----------------------------------------------------------------
  // Only the bank chosen by the bank select flag is written or read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int b = 0; b < crs_pkg::BANKS; b++) begin
        for (int k = 0; k < crs_pkg::BANKED; k++) begin
          bank_reg[b][k] <= crs_pkg::RST_WORD;
        end
      end
    end else if (wr_en) begin
      for (int k = 0; k < crs_pkg::BANKED; k++) begin
        // Byte lanes give independent high and low halves.
        if (widx == 6'(k)) begin
          bank_reg[cur_bank][k] <= merge(bank_reg[cur_bank][k], pwdata[15:0],
                                         wmask[15:0]);
        end
      end
      // Pair writes: the later register forms the upper half.
      unique case (widx)
        crs_pkg::IDX_PAIR_LO: begin
          bank_reg[cur_bank][0] <= merge(bank_reg[cur_bank][0], pwdata[15:0],
                                         wmask[15:0]);
          bank_reg[cur_bank][2] <= merge(bank_reg[cur_bank][2], pwdata[31:16],
                                         wmask[31:16]);
        end
        crs_pkg::IDX_PAIR_HI: begin
          bank_reg[cur_bank][1] <= merge(bank_reg[cur_bank][1], pwdata[15:0],
                                         wmask[15:0]);
          bank_reg[cur_bank][3] <= merge(bank_reg[cur_bank][3], pwdata[31:16],
                                         wmask[31:16]);
        end
        crs_pkg::IDX_APAIR: begin
          bank_reg[cur_bank][4] <= merge(bank_reg[cur_bank][4], pwdata[15:0],
                                         wmask[15:0]);
          bank_reg[cur_bank][5] <= merge(bank_reg[cur_bank][5], pwdata[31:16],
                                         wmask[31:16]);
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Static base and vector table base
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      static_base <= crs_pkg::RST_WORD;
    end else if (wr_en && widx == crs_pkg::IDX_STATIC) begin
      static_base <= merge(static_base, pwdata[15:0], wmask[15:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vect_base <= crs_pkg::RST_WIDE;
    end else if (wr_en && widx == crs_pkg::IDX_VECT) begin
      vect_base[15:0] <= merge(vect_base[15:0], pwdata[15:0], wmask[15:0]);
      if (pstrb[2]) begin
        vect_base[19:16] <= pwdata[19:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Next fetch pointer
  // ----------------------------------------------------------------
  // A core load takes priority over a software write in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_ptr <= crs_pkg::RST_WIDE;
    end else if (fetch_load) begin
      fetch_ptr <= fetch_value;
    end else if (wr_en && widx == crs_pkg::IDX_FETCH) begin
      fetch_ptr[15:0] <= merge(fetch_ptr[15:0], pwdata[15:0], wmask[15:0]);
      if (pstrb[2]) begin
        fetch_ptr[19:16] <= pwdata[19:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Stack pointers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_stack_pointer <= crs_pkg::RST_WORD;
      interrupt_stack_pointer <= crs_pkg::RST_WORD;
    end else begin
      if (sp_load && flags.u) begin
        user_stack_pointer <= sp_value;
      end else if (wr_en && (widx == crs_pkg::IDX_USP ||
                             (widx == crs_pkg::IDX_ACT_SP && flags.u))) begin
        user_stack_pointer <= merge(user_stack_pointer, pwdata[15:0], wmask[15:0]);
      end
      if (sp_load && !flags.u) begin
        interrupt_stack_pointer <= sp_value;
      end else if (wr_en && (widx == crs_pkg::IDX_ISP ||
                             (widx == crs_pkg::IDX_ACT_SP && !flags.u))) begin
        interrupt_stack_pointer <= merge(interrupt_stack_pointer, pwdata[15:0],
                                         wmask[15:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Flag word
  // ----------------------------------------------------------------
  // Hardware events are applied after a software write so that they win.
  always_comb begin
    next_flags = flags;
    if (wr_en && widx == crs_pkg::IDX_FLAG) begin
      if (pstrb[0]) begin
        next_flags[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        next_flags[10:8] = pwdata[10:8];
      end
    end
    if (alu_upd.valid) begin
      next_flags.c = alu_upd.carry;
      next_flags.z = (alu_upd.result == 16'h0000);
      next_flags.s = alu_upd.result[15];
      next_flags.o = alu_upd.ovf;
    end
    if (irq_ack) begin
      next_flags.i = 1'b0;
    end
    if (irq_ack || trap_low) begin
      next_flags.u = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= crs_pkg::crs_flag_t'(crs_pkg::RST_FLAG);
    end else begin
      flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt eligibility
  // ----------------------------------------------------------------
  // Maskable requests also need the enable flag; others only the level.
  assign irq_eligible = irq_req.pending && (irq_req.prio > flags.processor_priority_level) &&
                        (!irq_req.maskable || flags.i);

  // ----------------------------------------------------------------
  // Views
  // ----------------------------------------------------------------
  assign cpu_flag_word = flags;
  assign active_stack_pointer = flags.u ? user_stack_pointer
                                        : interrupt_stack_pointer;
  assign data_pair_low = {bank_reg[cur_bank][2], bank_reg[cur_bank][0]};
  assign data_pair_high = {bank_reg[cur_bank][3], bank_reg[cur_bank][1]};
  assign addr_reg_pair = {bank_reg[cur_bank][5], bank_reg[cur_bank][4]};
  assign frame_base_pointer = bank_reg[cur_bank][6];
  assign static_base_pointer = static_base;
  assign vector_table_base = vect_base;
  assign next_fetch_pointer = fetch_ptr;

  // ----------------------------------------------------------------
  // APB read and answer
  // ----------------------------------------------------------------
  // Zero wait states; an unmapped or unaligned address answers an error.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite && mapped) begin
      if (widx < 6'(crs_pkg::BANKED)) begin
        prdata[15:0] = bank_reg[cur_bank][widx[2:0]];
      end else begin
        unique case (widx)
          crs_pkg::IDX_STATIC: prdata[15:0] = static_base;
          crs_pkg::IDX_VECT: prdata[19:0] = vect_base;
          crs_pkg::IDX_FETCH: prdata[19:0] = fetch_ptr;
          crs_pkg::IDX_USP: prdata[15:0] = user_stack_pointer;
          crs_pkg::IDX_ISP: prdata[15:0] = interrupt_stack_pointer;
          crs_pkg::IDX_FLAG: prdata[10:0] = flags;
          crs_pkg::IDX_ACT_SP: prdata[15:0] = active_stack_pointer;
          crs_pkg::IDX_PAIR_LO: prdata = data_pair_low;
          crs_pkg::IDX_PAIR_HI: prdata = data_pair_high;
          crs_pkg::IDX_APAIR: prdata = addr_reg_pair;
          default: prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ack_clears_enable;
    @(posedge pclk) disable iff (!presetn)
      irq_ack |=> !flags.i && !flags.u;
  endproperty
  a_ack_clears_enable: assert property (p_ack_clears_enable)
    else $error("Acknowledge did not clear enable and stack select.");

  property p_trap_low_clears_u;
    @(posedge pclk) disable iff (!presetn)
      trap_exec && trap_num <= crs_pkg::TRAP_CLR_MAX |=> !flags.u;
  endproperty
  a_trap_low_clears_u: assert property (p_trap_low_clears_u)
    else $error("Low trap number did not clear stack select.");

  property p_trap_high_keeps_u;
    @(posedge pclk) disable iff (!presetn)
      trap_exec && trap_num > crs_pkg::TRAP_CLR_MAX && !irq_ack && !wr_en |=> $stable(flags.u);
  endproperty
  a_trap_high_keeps_u: assert property (p_trap_high_keeps_u)
    else $error("High trap number changed stack select.");

  property p_zero_flag;
    @(posedge pclk) disable iff (!presetn)
      alu_upd.valid |=> flags.z == ($past(alu_upd.result) == 16'h0000);
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("Zero flag does not match the result.");

  property p_sign_carry_ovf;
    @(posedge pclk) disable iff (!presetn)
      alu_upd.valid |=> flags.s == $past(alu_upd.result[15]) &&
                        flags.c == $past(alu_upd.carry) &&
                        flags.o == $past(alu_upd.ovf);
  endproperty
  a_sign_carry_ovf: assert property (p_sign_carry_ovf)
    else $error("Sign, carry or overflow flag is wrong.");

  property p_active_sp;
    @(posedge pclk) disable iff (!presetn)
      sp_load && !irq_ack && !trap_low && !wr_en |=> active_stack_pointer == $past(sp_value);
  endproperty
  a_active_sp: assert property (p_active_sp)
    else $error("Active stack pointer follows the wrong flag.");

  property p_priority_gate;
    @(posedge pclk) disable iff (!presetn)
      irq_req.pending && irq_req.prio <= flags.processor_priority_level |-> !irq_eligible;
  endproperty
  a_priority_gate: assert property (p_priority_gate)
    else $error("Request at or below the level was accepted.");

  property p_mask_gate;
    @(posedge pclk) disable iff (!presetn)
      irq_req.maskable && !flags.i |-> !irq_eligible;
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("Maskable request accepted with enable flag clear.");

  property p_pair_write;
    @(posedge pclk) disable iff (!presetn)
      wr_en && widx == crs_pkg::IDX_PAIR_LO && pstrb == 4'hF
      |=> data_pair_low == $past(pwdata);
  endproperty
  a_pair_write: assert property (p_pair_write)
    else $error("Data pair write did not land in both halves.");

  property p_fetch_load;
    @(posedge pclk) disable iff (!presetn)
      fetch_load |=> next_fetch_pointer == $past(fetch_value);
  endproperty
  a_fetch_load: assert property (p_fetch_load)
    else $error("Fetch pointer did not take the loaded value.");

  c_irq_ack: cover property (@(posedge pclk) disable iff (!presetn)
    irq_eligible ##1 irq_ack);
  c_bank_switch: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(flags.b));
  c_pair_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en && widx == crs_pkg::IDX_APAIR);
endmodule
`default_nettype wire

//--- core/crs_pkg.sv
// Purpose: Shared constants and carriers of the CPU register set.
// Assumes: APB with 32-bit data; one register per aligned word.
// Notes: The flag word sits in the low 11 bits of its APB word.
package crs_pkg;
  // ----------------------------------------------------------------
  // Register map (word indices; byte address is 4 * index)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [5:0] IDX_DATA0 = 6'h00;
  localparam logic [5:0] IDX_DATA1 = 6'h01;
  localparam logic [5:0] IDX_DATA2 = 6'h02;
  localparam logic [5:0] IDX_DATA3 = 6'h03;
  localparam logic [5:0] IDX_ADDR0 = 6'h04;
  localparam logic [5:0] IDX_ADDR1 = 6'h05;
  localparam logic [5:0] IDX_FRAME = 6'h06;
  localparam logic [5:0] IDX_STATIC = 6'h07;
  localparam logic [5:0] IDX_VECT = 6'h08;
  localparam logic [5:0] IDX_FETCH = 6'h09;
  localparam logic [5:0] IDX_USP = 6'h0A;
  localparam logic [5:0] IDX_ISP = 6'h0B;
  localparam logic [5:0] IDX_FLAG = 6'h0C;
  localparam logic [5:0] IDX_ACT_SP = 6'h0D;
  localparam logic [5:0] IDX_PAIR_LO = 6'h0E;
  localparam logic [5:0] IDX_PAIR_HI = 6'h0F;
  localparam logic [5:0] IDX_APAIR = 6'h10;
  localparam logic [5:0] IDX_LAST = 6'h10;
  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int BANKS = 2;
  localparam int BANKED = 7;
  localparam int VECT_W = 20;
  localparam int FETCH_W = 20;
  localparam int FLAG_W = 11;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [19:0] RST_WIDE = 20'h00000;
  localparam logic [10:0] RST_FLAG = 11'h000;
  localparam logic [5:0] TRAP_CLR_MAX = 6'h1F;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] processor_priority_level;
    logic u;
    logic i;
    logic o;
    logic b;
    logic s;
    logic z;
    logic d;
    logic c;
  } crs_flag_t;
  typedef struct packed {
    logic valid;
    logic [15:0] result;
    logic carry;
    logic ovf;
  } crs_alu_t;
  typedef struct packed {
    logic pending;
    logic [2:0] prio;
    logic maskable;
  } crs_irq_t;
endpackage

//--- verif/tb_cpu_register_set_flags.sv
// Purpose: Self-checking bench for the CPU register set behind its APB port.
// Assumes: Zero wait state slave; core strobes are one-cycle pulses.
// Notes: Scenarios run in sequence; each task judges its own results.
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_register_set_flags;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
  logic [crs_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdv, data_pair_low, data_pair_high, addr_reg_pair;
  logic [3:0] pstrb;
  crs_pkg::crs_alu_t alu_upd;
  crs_pkg::crs_irq_t irq_req;
  crs_pkg::crs_flag_t cpu_flag_word;
  logic irq_ack, trap_exec, fetch_load, sp_load, irq_eligible;
  logic [5:0] trap_num;
  logic [19:0] fetch_value, vector_table_base, next_fetch_pointer;
  logic [15:0] sp_value, active_stack_pointer, frame_base_pointer, static_base_pointer;
  int n_mismatch, checks_done, cycles;

  crs_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alu_upd(alu_upd), .irq_ack(irq_ack),
    .trap_exec(trap_exec), .trap_num(trap_num), .fetch_load(fetch_load),
    .fetch_value(fetch_value), .sp_load(sp_load), .sp_value(sp_value), .irq_req(irq_req),
    .cpu_flag_word(cpu_flag_word), .active_stack_pointer(active_stack_pointer),
    .data_pair_low(data_pair_low), .data_pair_high(data_pair_high),
    .addr_reg_pair(addr_reg_pair), .frame_base_pointer(frame_base_pointer),
    .static_base_pointer(static_base_pointer), .vector_table_base(vector_table_base),
    .next_fetch_pointer(next_fetch_pointer), .irq_eligible(irq_eligible));

  // ----------------------------------------------------------------
  // Clock, timeout and closing report
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [32:0] exp, input logic [32:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask

  // One APB transfer; the answer is taken at the edge that sees pready high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Lets a committed write settle before the caller looks at outputs.
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [32:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(name, exp, {errv, rdv});
  endtask

  // Ends the strobes driven at the previous edge and lets outputs settle.
  task automatic settle();
    @(posedge pclk);
    alu_upd.valid <= 1'b0;
    irq_ack <= 1'b0;
    trap_exec <= 1'b0;
    fetch_load <= 1'b0;
    sp_load <= 1'b0;
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_data();
    logic [15:0] v[4];
    v = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0};
    for (int k = 0; k < 4; k++) begin
      wr(8'(4 * k), {16'hFFFF, v[k]});
      rd("data reg", 8'(4 * k), {17'h0, v[k]});
    end
    chk("pair low", {1'b0, v[2], v[0]}, {1'b0, data_pair_low});
    chk("pair high", {1'b0, v[3], v[1]}, {1'b0, data_pair_high});
    rd("pair low rd", 8'h38, {1'b0, v[2], v[0]});
    wr(8'h38, 32'h55AA_1234);
    rd("pair low wr", 8'h08, 33'h0_0000_55AA);
    wr(8'h3C, 32'h0F0F_5678);
    rd("pair high wr", 8'h0C, 33'h0_0000_0F0F);
    apb(1'b1, 8'h00, 32'h0000_00EE, 4'b0001);
    apb(1'b1, 8'h04, 32'h0000_CC00, 4'b0010);
    rd("low byte", 8'h00, 33'h0_0000_12EE);
    rd("high byte", 8'h04, 33'h0_0000_CC78);
  endtask

  task automatic t_addr();
    wr(8'h10, 32'h0000_1357);
    wr(8'h14, 32'h0000_2468);
    chk("addr pair", 33'h0_2468_1357, {1'b0, addr_reg_pair});
    rd("addr pair rd", 8'h40, 33'h0_2468_1357);
    wr(8'h40, 32'h0ACE_0BDF);
    rd("addr one", 8'h14, 33'h0_0000_0ACE);
    wr(8'h18, 32'h0000_AAAA);
    wr(8'h1C, 32'h0000_5555);
    chk("frame", 33'h0_0000_AAAA, {17'h0, frame_base_pointer});
    chk("static", 33'h0_0000_5555, {17'h0, static_base_pointer});
    wr(8'h20, 32'hFFFF_FFFF);
    rd("vector", 8'h20, 33'h0_000F_FFFF);
    chk("vector out", 33'h0_000F_FFFF, {13'h0, vector_table_base});
    wr(8'h24, 32'h0001_2345);
    rd("fetch wr", 8'h24, 33'h0_0001_2345);
    @(posedge pclk);
    fetch_load <= 1'b1;
    fetch_value <= 20'hABCDE;
    settle();
    chk("fetch out", 33'h0_000A_BCDE, {13'h0, next_fetch_pointer});
    rd("fetch rd", 8'h24, 33'h0_000A_BCDE);
  endtask

  task automatic t_stack();
    wr(8'h28, 32'h0000_1111);
    wr(8'h2C, 32'h0000_2222);
    chk("isp active", 33'h0_0000_2222, {17'h0, active_stack_pointer});
    wr(8'h30, 32'h0000_0080);
    rd("usp active", 8'h34, 33'h0_0000_1111);
    @(posedge pclk);
    sp_load <= 1'b1;
    sp_value <= 16'h3333;
    settle();
    rd("usp loaded", 8'h28, 33'h0_0000_3333);
    rd("isp kept", 8'h2C, 33'h0_0000_2222);
  endtask

  task automatic t_ack();
    wr(8'h30, 32'h0000_03C0);
    @(posedge pclk);
    irq_ack <= 1'b1;
    settle();
    chk("ack flags", 33'h0_0000_0300, {22'h0, cpu_flag_word});
    chk("ack sp", 33'h0_0000_2222, {17'h0, active_stack_pointer});
    wr(8'h30, 32'h0000_03C0);
    @(posedge pclk);
    trap_exec <= 1'b1;
    trap_num <= 6'd32;
    settle();
    chk("trap 32", 33'h0_0000_03C0, {22'h0, cpu_flag_word});
    @(posedge pclk);
    trap_exec <= 1'b1;
    trap_num <= 6'd31;
    settle();
    chk("trap 31", 33'h0_0000_0340, {22'h0, cpu_flag_word});
  endtask

  task automatic t_irq();
    logic [10:0] f[6];
    logic [4:0] q[6];
    logic e[6];
    f = '{11'h340, 11'h340, 11'h300, 11'h300, 11'h7C0, 11'h040};
    q = '{5'b10111, 5'b11001, 5'b11001, 5'b11000, 5'b11110, 5'b01111};
    e = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    for (int k = 0; k < 6; k++) begin
      wr(8'h30, {21'h0, f[k]});
      @(posedge pclk);
      irq_req <= q[k];
      @(posedge pclk);
      #1;
      chk("eligible", {32'h0, e[k]}, {32'h0, irq_eligible});
    end
    @(posedge pclk);
    irq_req <= 5'b00000;
  endtask

  task automatic t_alu();
    logic [17:0] u[3];
    logic [10:0] x[3];
    u = '{{16'h0000, 2'b10}, {16'h8000, 2'b01}, {16'h0001, 2'b00}};
    x = '{11'h005, 11'h028, 11'h000};
    wr(8'h30, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      alu_upd <= {1'b1, u[k]};
      settle();
      chk("alu flags", {22'h0, x[k]}, {22'h0, cpu_flag_word});
    end
  endtask

  task automatic t_bank();
    wr(8'h30, 32'h0000_0010);
    rd("bank1 data", 8'h00, 33'h0_0000_0000);
    wr(8'h00, 32'h0000_BEEF);
    rd("bank1 write", 8'h00, 33'h0_0000_BEEF);
    rd("shared static", 8'h1C, 33'h0_0000_5555);
    wr(8'h30, 32'h0000_0000);
    rd("bank0 data", 8'h00, 33'h0_0000_12EE);
  endtask

  task automatic t_misc();
    rd("unmapped", 8'h44, 33'h1_0000_0000);
    rd("unaligned", 8'h02, 33'h1_0000_0000);
    // Debug flag left at zero by software.
    wr(8'h30, 32'hFFFF_FFFD);
    rd("flag width", 8'h30, 33'h0_0000_07FD);
    wr(8'h30, 32'h0000_0000);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("reset flags", 33'h0, {22'h0, cpu_flag_word});
    rd("reset data", 8'h00, 33'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    cycles = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {irq_ack, trap_exec, trap_num, fetch_load, fetch_value, sp_load, sp_value} = '0;
    alu_upd = '0;
    irq_req = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd("reset flag rd", 8'h30, 33'h0);
    t_data();
    t_addr();
    t_stack();
    t_ack();
    t_irq();
    t_alu();
    t_bank();
    t_misc();
    end_sim();
  end
endmodule
`default_nettype wire
